/* File: verilog/dsr_regs.svh */
// register offsets, field positions and reset values of the diagnostic status bank
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

`define DSR_ADDR_CRC_LO 8'h55
`define DSR_ADDR_CRC_HI 8'h56
`define DSR_ADDR_ALARM 8'h57
`define DSR_ADDR_PIN0_EXT 8'h58
`define DSR_ADDR_PIN1_EXT 8'h59
`define DSR_ADDR_TEMP_EXT 8'h5A
`define DSR_ADDR_RSVD_5B 8'h5B
`define DSR_ADDR_PKT_CNT 8'h5C
`define DSR_ADDR_PKT_FLAGS 8'h5D
`define DSR_ADDR_IRQ_STAT 8'h80
`define DSR_ADDR_IRQ_EN 8'h81
`define DSR_ADDR_IRQ_CLR 8'h82

`define DSR_ALARM_TEMP_OVER 5
`define DSR_ALARM_TEMP_UNDER 4
`define DSR_ALARM_PIN1_OVER 3
`define DSR_ALARM_PIN1_UNDER 2
`define DSR_ALARM_PIN0_OVER 1
`define DSR_ALARM_PIN0_UNDER 0

`define DSR_PKT_SHORT_LINE 3
`define DSR_PKT_CHECKSUM 2
`define DSR_PKT_HDR_DOUBLE 1
`define DSR_PKT_HDR_SINGLE 0

`define DSR_EXT_PEAK_LSB 4
`define DSR_EXT_TROUGH_LSB 0
`define DSR_PEAK_RST 3'h0
`define DSR_TROUGH_RST 3'h7
`define DSR_READ_W 3

`define DSR_IRQ_ALARM 0
`define DSR_IRQ_PKT_ERR 1
`define DSR_IRQ_CRC_ERR 2
`define DSR_IRQ_PKT_SAT 3
`define DSR_IRQ_W 4

`define DSR_CNT_MAX 8'hFF
`define DSR_CRC_MAX 16'hFFFF

`endif

/* File: verilog/dsr_pkg.sv */
// types shared by the diagnostic status bank
package dsr_pkg;
  typedef logic [7:0] dsr_addr_t;
  typedef logic [7:0] dsr_data_t;
  typedef logic [15:0] dsr_tally_t;
endpackage : dsr_pkg

/* File: verilog/dsr_extreme.sv */
// one monitor: limit compare, alarm levels and clear-on-read peak and trough capture
`timescale 1ns/100ps
module dsr_extreme #(
  parameter int W = 3
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic sample_valid,
  input wire logic [W-1:0] reading,
  input wire logic [W-1:0] upper_limit,
  input wire logic [W-1:0] lower_limit,
  input wire logic clr,
  output logic over_lvl,
  output logic under_lvl,
  output logic [W-1:0] peak,
  output logic [W-1:0] trough
);
  logic [W-1:0] reading_q;
  logic over_q;
  logic under_q;
  logic [W-1:0] peak_q;
  logic [W-1:0] trough_q;

  // alarm levels hold from one sample to the next, so a cleared capture can reload
  always_ff @(posedge clk) begin
    if (srst) begin
      reading_q <= '0;
      over_q <= 1'b0;
      under_q <= 1'b0;
    end else if (sample_valid) begin
      reading_q <= reading;
      over_q <= (reading > upper_limit);
      under_q <= (reading < lower_limit);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      peak_q <= '0;
    end else if (clr) begin
      peak_q <= over_q ? reading_q : '0;
    end else if (over_q && (reading_q > peak_q)) begin
      peak_q <= reading_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      trough_q <= '1;
    end else if (clr) begin
      trough_q <= under_q ? reading_q : '1;
    end else if (under_q && (reading_q < trough_q)) begin
      trough_q <= reading_q;
    end
  end

  assign over_lvl = over_q;
  assign under_lvl = under_q;
  assign peak = peak_q;
  assign trough = trough_q;
endmodule : dsr_extreme

/* File: verilog/dsr_status_regs.sv */
// diagnostic status register bank: crc tally, monitor alarms and extremes, packet errors
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
`include "dsr_regs.svh"

module dsr_status_regs #(
  parameter int READ_W = `DSR_READ_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire dsr_pkg::dsr_addr_t reg_addr,
  input wire dsr_pkg::dsr_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output dsr_pkg::dsr_data_t reg_rdata,
  input wire logic crc_err_pulse,
  input wire logic crc_tally_clr,
  input wire logic temp_sample_valid,
  input wire logic [READ_W-1:0] temp_reading,
  input wire logic [READ_W-1:0] temp_upper_limit,
  input wire logic [READ_W-1:0] temp_lower_limit,
  input wire logic pin0_sample_valid,
  input wire logic [READ_W-1:0] pin0_reading,
  input wire logic [READ_W-1:0] pin0_upper_limit,
  input wire logic [READ_W-1:0] pin0_lower_limit,
  input wire logic pin1_sample_valid,
  input wire logic [READ_W-1:0] pin1_reading,
  input wire logic [READ_W-1:0] pin1_upper_limit,
  input wire logic [READ_W-1:0] pin1_lower_limit,
  input wire logic pkt_done,
  input wire logic short_line_flag,
  input wire logic payload_check_fail,
  input wire logic header_double_fault,
  input wire logic header_single_fault,
  output logic irq
);
  import dsr_pkg::*;

  // the extreme fields are three bits wide in the map; nothing else fits them
  if (READ_W != `DSR_READ_W) begin : g_width_check
    $error("dsr_status_regs: READ_W must be 3");
  end

  function automatic logic rd_at(input dsr_addr_t a, input logic rd, input dsr_addr_t at);
    return rd && (a == at);
  endfunction : rd_at

  function automatic logic [2:0] fit3(input logic [READ_W-1:0] v);
    return 3'(v);
  endfunction : fit3

  logic clr_alarm;
  logic clr_pin0;
  logic clr_pin1;
  logic clr_temp;
  logic clr_pkt_cnt;
  logic clr_pkt_flags;

  assign clr_alarm = rd_at(reg_addr, reg_rd, `DSR_ADDR_ALARM);
  assign clr_pin0 = rd_at(reg_addr, reg_rd, `DSR_ADDR_PIN0_EXT);
  assign clr_pin1 = rd_at(reg_addr, reg_rd, `DSR_ADDR_PIN1_EXT);
  assign clr_temp = rd_at(reg_addr, reg_rd, `DSR_ADDR_TEMP_EXT);
  assign clr_pkt_cnt = rd_at(reg_addr, reg_rd, `DSR_ADDR_PKT_CNT);
  assign clr_pkt_flags = rd_at(reg_addr, reg_rd, `DSR_ADDR_PKT_FLAGS);

  // crc tally: counting stays here, clearing comes from the back-channel control
  dsr_tally_t crc_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      crc_q <= '0;
    end else if (crc_tally_clr) begin
      crc_q <= crc_err_pulse ? 16'h0001 : 16'h0000;
    end else if (crc_err_pulse && (crc_q != `DSR_CRC_MAX)) begin
      crc_q <= crc_q + 16'h0001;
    end
  end

  logic temp_over;
  logic temp_under;
  logic pin0_over;
  logic pin0_under;
  logic pin1_over;
  logic pin1_under;
  logic [READ_W-1:0] temp_peak;
  logic [READ_W-1:0] temp_trough;
  logic [READ_W-1:0] pin0_peak_reading;
  logic [READ_W-1:0] pin0_trough_reading;
  logic [READ_W-1:0] pin1_peak_reading;
  logic [READ_W-1:0] pin1_trough_reading;

  dsr_extreme #(.W(READ_W)) u_temp (
    .clk(clk),
    .srst(srst),
    .sample_valid(temp_sample_valid),
    .reading(temp_reading),
    .upper_limit(temp_upper_limit),
    .lower_limit(temp_lower_limit),
    .clr(clr_temp),
    .over_lvl(temp_over),
    .under_lvl(temp_under),
    .peak(temp_peak),
    .trough(temp_trough)
  );

  dsr_extreme #(.W(READ_W)) u_pin0 (
    .clk(clk),
    .srst(srst),
    .sample_valid(pin0_sample_valid),
    .reading(pin0_reading),
    .upper_limit(pin0_upper_limit),
    .lower_limit(pin0_lower_limit),
    .clr(clr_pin0),
    .over_lvl(pin0_over),
    .under_lvl(pin0_under),
    .peak(pin0_peak_reading),
    .trough(pin0_trough_reading)
  );

  dsr_extreme #(.W(READ_W)) u_pin1 (
    .clk(clk),
    .srst(srst),
    .sample_valid(pin1_sample_valid),
    .reading(pin1_reading),
    .upper_limit(pin1_upper_limit),
    .lower_limit(pin1_lower_limit),
    .clr(clr_pin1),
    .over_lvl(pin1_over),
    .under_lvl(pin1_under),
    .peak(pin1_peak_reading),
    .trough(pin1_trough_reading)
  );

  // alarm flags follow the held levels, so a clear does not take on a flag whose level is still true on that edge
  logic [5:0] alarm_set;
  logic [5:0] alarm_q;
  always_comb begin
    alarm_set = '0;
    alarm_set[`DSR_ALARM_TEMP_OVER] = temp_over;
    alarm_set[`DSR_ALARM_TEMP_UNDER] = temp_under;
    alarm_set[`DSR_ALARM_PIN1_OVER] = pin1_over;
    alarm_set[`DSR_ALARM_PIN1_UNDER] = pin1_under;
    alarm_set[`DSR_ALARM_PIN0_OVER] = pin0_over;
    alarm_set[`DSR_ALARM_PIN0_UNDER] = pin0_under;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      alarm_q <= '0;
    end else begin
      alarm_q <= (alarm_q & ~{6{clr_alarm}}) | alarm_set;
    end
  end

  // packet error causes are qualified by the end-of-packet strobe
  logic [3:0] pkt_set;
  logic [3:0] pkt_flags_q;
  logic pkt_bad;
  always_comb begin
    pkt_set = '0;
    pkt_set[`DSR_PKT_SHORT_LINE] = pkt_done & short_line_flag;
    pkt_set[`DSR_PKT_CHECKSUM] = pkt_done & payload_check_fail;
    pkt_set[`DSR_PKT_HDR_DOUBLE] = pkt_done & header_double_fault;
    pkt_set[`DSR_PKT_HDR_SINGLE] = pkt_done & header_single_fault;
  end
  assign pkt_bad = |pkt_set;

  always_ff @(posedge clk) begin
    if (srst) begin
      pkt_flags_q <= '0;
    end else begin
      pkt_flags_q <= (pkt_flags_q & ~{4{clr_pkt_flags}}) | pkt_set;
    end
  end

  // a bad packet in the reading cycle is kept as the first count of the new window
  dsr_data_t bad_packet_tally_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      bad_packet_tally_q <= '0;
    end else if (clr_pkt_cnt) begin
      bad_packet_tally_q <= pkt_bad ? 8'h01 : 8'h00;
    end else if (pkt_bad && (bad_packet_tally_q != `DSR_CNT_MAX)) begin
      bad_packet_tally_q <= bad_packet_tally_q + 8'h01;
    end
  end

  // interrupt events; enable and write-one-to-clear registers share the layout
  logic [`DSR_IRQ_W-1:0] irq_evt;
  logic [`DSR_IRQ_W-1:0] irq_stat_q;
  logic [`DSR_IRQ_W-1:0] irq_en_q;
  logic [`DSR_IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_evt = '0;
    irq_evt[`DSR_IRQ_ALARM] = |(alarm_set & ~alarm_q);
    irq_evt[`DSR_IRQ_PKT_ERR] = pkt_bad;
    irq_evt[`DSR_IRQ_CRC_ERR] = crc_err_pulse;
    irq_evt[`DSR_IRQ_PKT_SAT] = pkt_bad && !clr_pkt_cnt &&
                                (bad_packet_tally_q == (`DSR_CNT_MAX - 8'h01));
  end
  assign irq_clr = (reg_wr && (reg_addr == `DSR_ADDR_IRQ_CLR)) ?
                   reg_wdata[`DSR_IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      irq_en_q <= '0;
    end else if (reg_wr && (reg_addr == `DSR_ADDR_IRQ_EN)) begin
      irq_en_q <= reg_wdata[`DSR_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // read mux sees pre-clear values; the clear lands on the same edge as the capture
  dsr_data_t rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `DSR_ADDR_CRC_LO: rd_mux = crc_q[7:0];
      `DSR_ADDR_CRC_HI: rd_mux = crc_q[15:8];
      `DSR_ADDR_ALARM: rd_mux = {2'b00, alarm_q};
      `DSR_ADDR_PIN0_EXT: rd_mux = {1'b0, fit3(pin0_peak_reading), 1'b0,
                                    fit3(pin0_trough_reading)};
      `DSR_ADDR_PIN1_EXT: rd_mux = {1'b0, fit3(pin1_peak_reading), 1'b0,
                                    fit3(pin1_trough_reading)};
      `DSR_ADDR_TEMP_EXT: rd_mux = {1'b0, fit3(temp_peak), 1'b0,
                                    fit3(temp_trough)};
      `DSR_ADDR_PKT_CNT: rd_mux = bad_packet_tally_q;
      `DSR_ADDR_PKT_FLAGS: rd_mux = {4'h0, pkt_flags_q};
      `DSR_ADDR_IRQ_STAT: rd_mux = {4'h0, irq_stat_q};
      `DSR_ADDR_IRQ_EN: rd_mux = {4'h0, irq_en_q};
      default: rd_mux = '0;
    endcase
  end

  // data stands only in the cycle after the strobe, zero otherwise
  dsr_data_t rdata_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  crc_high_read_a: assert property (
    reg_rd && reg_addr == `DSR_ADDR_CRC_HI |=> reg_rdata == $past(crc_q[15:8]))
    else $error("crc high byte read mismatch");

  crc_low_read_a: assert property (
    reg_rd && reg_addr == `DSR_ADDR_CRC_LO |=> reg_rdata == $past(crc_q[7:0]))
    else $error("crc low byte read mismatch");

  temp_over_flag_a: assert property (
    temp_sample_valid && temp_reading > temp_upper_limit |=> ##1 alarm_q[5])
    else $error("temperature over alarm not set");

  temp_under_flag_a: assert property (
    temp_sample_valid && temp_reading < temp_lower_limit |=> ##1 alarm_q[4])
    else $error("temperature under alarm not set");

  pin1_flags_a: assert property (
    pin1_sample_valid && pin1_reading > pin1_upper_limit |=> ##1 alarm_q[3])
    else $error("pin 1 over alarm not set");

  pin0_flags_a: assert property (
    pin0_sample_valid && pin0_reading < pin0_lower_limit |=> ##1 alarm_q[0])
    else $error("pin 0 under alarm not set");

  alarm_read_clear_a: assert property (
    clr_alarm && alarm_set == 6'h00 |=> alarm_q == 6'h00)
    else $error("alarm flags not cleared by read");

  pin0_peak_clear_a: assert property (
    clr_pin0 && !pin0_over |=> pin0_peak_reading == `DSR_PEAK_RST)
    else $error("pin 0 peak not cleared to zero");

  pin0_trough_clear_a: assert property (
    clr_pin0 && !pin0_under |=> pin0_trough_reading == `DSR_TROUGH_RST)
    else $error("pin 0 trough not cleared to seven");

  pin1_peak_hold_a: assert property (
    !clr_pin1 |=> pin1_peak_reading >= $past(pin1_peak_reading))
    else $error("pin 1 peak fell without a read");

  pin1_trough_hold_a: assert property (
    !clr_pin1 |=> pin1_trough_reading <= $past(pin1_trough_reading))
    else $error("pin 1 trough rose without a read");

  // the peak outlives a read of the alarm flags, so only its own read may drop it
  temp_peak_clear_a: assert property (
    clr_temp && !temp_over |=> temp_peak == `DSR_PEAK_RST)
    else $error("temperature peak not cleared to zero");

  temp_trough_read_a: assert property (
    clr_temp |=> reg_rdata[2:0] == $past(fit3(temp_trough)))
    else $error("temperature trough read mismatch");

  pkt_count_step_a: assert property (
    pkt_bad && !clr_pkt_cnt && bad_packet_tally_q != `DSR_CNT_MAX
    |=> bad_packet_tally_q == $past(bad_packet_tally_q) + 8'h01)
    else $error("bad packet tally did not step");

  pkt_count_read_a: assert property (
    clr_pkt_cnt && !pkt_bad |=> bad_packet_tally_q == 8'h00)
    else $error("bad packet tally not restarted by read");

  short_line_set_a: assert property (
    pkt_done && short_line_flag |=> pkt_flags_q[3])
    else $error("short line flag not set");

  checksum_set_a: assert property (
    pkt_done && payload_check_fail |=> pkt_flags_q[2])
    else $error("payload checksum flag not set");

  header_faults_a: assert property (
    pkt_done && (header_double_fault || header_single_fault)
    |=> pkt_flags_q[1:0] != 2'b00)
    else $error("header code fault flag not set");

  set_beats_clear_a: assert property (
    clr_pkt_flags && pkt_set != 4'h0 |=> (pkt_flags_q & $past(pkt_set)) == $past(pkt_set))
    else $error("packet flag lost when set met clearing read");

  pkt_saturate_a: assert property (
    bad_packet_tally_q == `DSR_CNT_MAX && !clr_pkt_cnt |=> bad_packet_tally_q == `DSR_CNT_MAX)
    else $error("bad packet tally wrapped");

endmodule : dsr_status_regs

/* File: tb/tb_dsr_status_regs.sv */
// self-checking bench for the diagnostic status register bank
`timescale 1ns/100ps
module tb_dsr_status_regs;
  import dsr_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  dsr_addr_t reg_addr = 8'h00;
  dsr_data_t reg_wdata = 8'h00;
  dsr_data_t reg_rdata;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic crc_err_pulse = 1'b0;
  logic crc_tally_clr = 1'b0;
  logic pkt_done = 1'b0;
  logic [3:0] cause = 4'h0;
  logic [2:0] vld = 3'h0;
  logic [2:0] rdg [3] = '{3'h3, 3'h3, 3'h3};
  logic [2:0] up_lim [3] = '{3'h4, 3'h4, 3'h4};
  logic [2:0] lo_lim [3] = '{3'h2, 3'h2, 3'h2};
  logic irq;
  logic rd_pend = 1'b0;
  logic [15:0] note_q;
  logic [15:0] expq [$];
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 52610;

  always #25 clk = ~clk;

  dsr_status_regs #(.READ_W(3)) u_dsr_status_regs (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .crc_err_pulse(crc_err_pulse), .crc_tally_clr(crc_tally_clr),
    .temp_sample_valid(vld[2]), .temp_reading(rdg[2]),
    .temp_upper_limit(up_lim[2]), .temp_lower_limit(lo_lim[2]),
    .pin0_sample_valid(vld[0]), .pin0_reading(rdg[0]),
    .pin0_upper_limit(up_lim[0]), .pin0_lower_limit(lo_lim[0]),
    .pin1_sample_valid(vld[1]), .pin1_reading(rdg[1]),
    .pin1_upper_limit(up_lim[1]), .pin1_lower_limit(lo_lim[1]),
    .pkt_done(pkt_done), .short_line_flag(cause[3]), .payload_check_fail(cause[2]),
    .header_double_fault(cause[1]), .header_single_fault(cause[0]),
    .irq(irq)
  );

  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input dsr_addr_t a, input dsr_data_t d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // the expectation is noted as the strobe goes out; the watcher below pairs it
  task automatic rd(input dsr_addr_t a, input dsr_data_t e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    expq.push_back({a, e});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd

  task automatic chk_irq(input logic e);
    @(negedge clk);
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask : chk_irq

  task automatic samp(input int m, input logic [2:0] r);
    @(posedge clk);
    vld[m] <= 1'b1;
    rdg[m] <= r;
    @(posedge clk);
    vld[m] <= 1'b0;
  endtask : samp

  task automatic pkt(input logic [3:0] c);
    @(posedge clk);
    pkt_done <= 1'b1;
    cause <= c;
    @(posedge clk);
    pkt_done <= 1'b0;
    cause <= 4'h0;
  endtask : pkt

  task automatic note(input string name);
    $display("test %s done", name);
  endtask : note

  task end_sim();
    if (expq.size() != 0) begin
      error_cnt++;
      $display("Error read_queue expected 0 seen %0d", expq.size());
    end
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  // read data stand only in the cycle after the strobe, so compare mid-cycle there
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk) begin
    if (rd_pend) begin
      if (expq.size() == 0) begin
        error_cnt++;
        $display("Error read_queue expected note seen none");
      end else begin
        note_q = expq.pop_front();
        chk($sformatf("reg_%h", note_q[15:8]), note_q[7:0], reg_rdata); // tag sits at rd
      end
    end else if (!srst) begin
      chk("rdata_idle", 8'h00, reg_rdata);
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected done seen timeout");
    end_sim();
  end

  initial begin
    int n;
    int bad;
    int ob;
    int ub;
    logic [3:0] c;
    logic [3:0] fl;
    dsr_addr_t ea;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // writes to the status bank must not land anywhere
    for (int a = 'h55; a <= 'h5D; a++) wr(8'(a), 8'hFF);
    for (int a = 'h55; a <= 'h5D; a++) begin
      rd(8'(a), (a > 'h57 && a < 'h5B) ? 8'h07 : 8'h00);
    end
    rd(8'h80, 8'h00);
    rd(8'h81, 8'h00);
    rd(8'h40, 8'h00);
    note("reset");
    // 250 to 349 pulses, which carry into the high byte once past 255
    n = 250 + ($unsigned($random(seed)) % 100);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      crc_err_pulse <= 1'b1;
    end
    @(posedge clk);
    crc_err_pulse <= 1'b0;
    rd(8'h55, n[7:0]);
    rd(8'h56, n[15:8]);
    rd(8'h56, n[15:8]);
    @(posedge clk);
    crc_tally_clr <= 1'b1;
    crc_err_pulse <= 1'b1;
    @(posedge clk);
    crc_tally_clr <= 1'b0;
    crc_err_pulse <= 1'b0;
    rd(8'h55, 8'h01);
    rd(8'h56, 8'h00);
    note("crc_tally");
    rd(8'h80, 8'h04);
    wr(8'h82, 8'h04);
    rd(8'h80, 8'h00);
    wr(8'h81, 8'h04);
    rd(8'h81, 8'h04);
    chk_irq(1'b0);
    @(posedge clk);
    crc_err_pulse <= 1'b1;
    @(posedge clk);
    crc_err_pulse <= 1'b0;
    tick(2);
    chk_irq(1'b1);
    wr(8'h81, 8'h00);
    chk_irq(1'b0);
    wr(8'h81, 8'h04);
    chk_irq(1'b1);
    wr(8'h82, 8'h04);
    chk_irq(1'b0);
    note("irq");
    // monitor 0 is pin 0, 1 is pin 1, 2 is temperature
    for (int m = 0; m < 3; m++) begin
      ob = 2 * m + 1;
      ub = 2 * m;
      ea = 8'h58 + 8'(m);
      samp(m, 3'h6);
      samp(m, 3'h5);
      samp(m, 3'h3);
      tick(3);
      rd(8'h57, 8'(1 << ob));
      rd(ea, 8'h67);
      rd(8'h57, 8'h00);
      rd(ea, 8'h07);
      samp(m, 3'h0);
      samp(m, 3'h1);
      samp(m, 3'h3);
      tick(3);
      rd(8'h57, 8'(1 << ub));
      rd(ea, 8'h00);
      rd(ea, 8'h07);
      samp(m, 3'h7);
      tick(3);
      rd(8'h57, 8'(1 << ob));
      rd(ea, 8'h77);
      tick(3);
      rd(8'h57, 8'(1 << ob));
      rd(ea, 8'h77);
      samp(m, 3'h3);
      tick(3);
      rd(8'h57, 8'(1 << ob));
      rd(8'h57, 8'h00);
      rd(ea, 8'h77);
      rd(ea, 8'h07);
    end
    note("monitors");
    for (int i = 0; i < 4; i++) pkt(4'(1 << i));
    rd(8'h5D, 8'h0F);
    rd(8'h5C, 8'h04);
    rd(8'h5C, 8'h00);
    rd(8'h5D, 8'h00);
    // causes outside a packet end are noise and must be ignored
    @(posedge clk);
    cause <= 4'hF;
    @(posedge clk);
    cause <= 4'h0;
    pkt(4'h0);
    pkt(4'h5);
    rd(8'h5C, 8'h01);
    rd(8'h5D, 8'h05);
    // a packet error meeting the clearing read must survive it
    pkt(4'h8);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= 8'h5D;
    expq.push_back({8'h5D, 8'h08});
    pkt_done <= 1'b1;
    cause <= 4'h4;
    @(posedge clk);
    reg_rd <= 1'b0;
    pkt_done <= 1'b0;
    cause <= 4'h0;
    rd(8'h5D, 8'h04);
    rd(8'h5C, 8'h02);
    bad = 0;
    fl = 4'h0;
    for (int i = 0; i < 300; i++) begin
      c = 4'($random(seed));
      @(posedge clk);
      pkt_done <= 1'b1;
      cause <= c;
      fl = fl | c;
      if (c != 4'h0) bad++;
    end
    @(posedge clk);
    pkt_done <= 1'b0;
    cause <= 4'h0;
    rd(8'h5D, {4'h0, fl});
    rd(8'h5C, (bad > 255) ? 8'hFF : 8'(bad));
    rd(8'h5C, 8'h00);
    rd(8'h80, (bad >= 255) ? 8'h0B : 8'h03);
    wr(8'h81, 8'h08);
    chk_irq(bad >= 255);
    wr(8'h82, 8'h08);
    chk_irq(1'b0);
    note("packets");
    tick(3);
    end_sim();
  end
endmodule : tb_dsr_status_regs
